// ==== slc_glass_model.sv ====
// passive model of the lcd glass: keeps the last segment row seen per common line
`timescale 1ns/10ps
module slc_glass_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // glass pins
  input wire logic [7:0] com_out,
  input wire logic [39:0] seg_out,
  // captured rows, 40 bits per common
  output logic [319:0] rows_r
);
  // ----------------------------------------
  // row capture
  // ----------------------------------------
  // a row is only taken while exactly one common is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rows_r <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (com_out == (8'h01 << i)) begin
          rows_r[i*40 +: 40] <= seg_out;
        end
      end
    end
  end
endmodule

// ==== slc_pkg.sv ====
// shared constants and types of the segment lcd controller
package slc_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int NUM_SEG = 40;
  localparam int SEG_AW = 6;
  localparam int SLOT_CYC = 64;
  localparam int CLK_MHZ = 125;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_VLEVEL = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_DISPOFF = 12'h00c;
  localparam logic [11:0] OFF_SEGDATA = 12'h100;
  localparam logic [11:0] OFF_SEGMOD = 12'h200;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int CT_DISP = 0;
  localparam int CT_CIRC = 1;
  localparam int CT_BINIT = 2;
  localparam int CT_WAVE = 3;
  localparam int CT_SLC = 4;
  localparam int CT_BIAS = 8;
  localparam int CT_GEN = 10;
  localparam int CT_AREA = 12;
  localparam int CT_CLK = 13;
  localparam int DO_OFF = 0;
  localparam int DO_STOP = 1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [4:0] VLEVEL_RST = 5'h0c;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [2:0] SLC_STATIC = 3'h0;
  localparam logic [2:0] SLC_TWO = 3'h1;
  localparam logic [2:0] SLC_THREE = 3'h2;
  localparam logic [2:0] SLC_FOUR = 3'h3;
  localparam logic [2:0] SLC_EIGHT = 3'h4;
  localparam logic [1:0] BIAS_HALF = 2'h0;
  localparam logic [1:0] BIAS_THIRD = 2'h1;
  localparam logic [1:0] BIAS_QUART = 2'h2;
  localparam logic [1:0] GEN_RES = 2'h0;
  localparam logic [1:0] GEN_BOOST = 2'h1;
  localparam logic [1:0] GEN_CAP = 2'h2;
  localparam logic AREA_A = 1'b0;
  localparam logic AREA_B = 1'b1;
  typedef enum {ST_IDLE, ST_WAIT} slc_bus_e;
endpackage

// ==== slc_seg_mem.sv ====
// display data store: one byte per segment, bus port and scan port
`timescale 1ns/10ps
module slc_seg_mem (
  // clock
  input wire logic pclk,
  // bus port
  input wire logic [slc_pkg::SEG_AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [7:0] a_wdata,
  output logic [7:0] a_q,
  // scan port
  input wire logic [slc_pkg::SEG_AW-1:0] b_addr,
  output logic [7:0] b_q
);
  import slc_pkg::*;
  logic [7:0] mem [0:NUM_SEG-1];
  always_ff @(posedge pclk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_q <= mem[a_addr];
    b_q <= mem[b_addr];
  end
endmodule

// ==== slc_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
module slc_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== slc_top.sv ====
// segment lcd controller: apb registers, display store, common scan, drive control
`timescale 1ns/10ps
// Notes on behaviour
// RL1: outside 8-slice mode, low nibble is A-pattern, high nibble is B-pattern.
// RL2: bit n of a segment byte drives common line n; outside 8-slice mode area B takes bit n+4 for common n.
// RL3: masked rewrite changes only selected bits; other stored bits stay unchanged.
// RL4: display area is A-pattern after reset unless software selects another.
// RL5: software picks a supported waveform, slice, bias and generator combination.
// RL6: software initialises in the documented order, circuit enable last.
// RL7: boost initial value and reference level programmed only for internal boosting.
// RL8: boost or capacitor split circuit enabled last, only for those generators.
// RL9: lcd clock source must run before initialisation, else it fails.
// RL10: pin function select done with port controls cleared, then mode set.
// RL11: display enabled only after init; when enabled stored pattern drives glass.
// RL12: display off alone, or display off plus stopping the circuit.
// RL13: stopped circuit makes the drive method fall back to resistor division.
// RL14: software waits out the boost wait time before enabling display.
module slc_top #(
  parameter int BOOST_WAIT_US = 5000,
  parameter int BOOST_WAIT_CYC = BOOST_WAIT_US * slc_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source status pin
  input wire logic lcd_clk_running,
  // drive control
  output logic [1:0] gen_sel_eff,
  output logic circuit_run,
  output logic boost_init_ctrl,
  output logic [4:0] ref_level,
  output logic [1:0] lcd_clk_sel,
  // glass
  output logic [7:0] com_out,
  output logic [slc_pkg::NUM_SEG-1:0] seg_out
);
  import slc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic mode_ok(input logic wave, input logic [2:0] slc,
                                   input logic [1:0] bias, input logic [1:0] gen);
    logic ok;
    ok = 1'b0;
    case (slc)
      SLC_EIGHT: ok = (bias == BIAS_QUART) && (gen == GEN_RES || gen == GEN_BOOST);
      SLC_FOUR: ok = (bias == BIAS_THIRD) && (gen <= GEN_CAP);
      SLC_THREE: ok = !wave && ((bias == BIAS_THIRD && gen <= GEN_CAP) ||
                                (bias == BIAS_HALF && gen == GEN_RES));
      SLC_TWO: ok = !wave && (bias == BIAS_HALF) && (gen == GEN_RES);
      SLC_STATIC: ok = !wave && (gen == GEN_RES);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [3:0] num_com(input logic [2:0] slc);
    logic [3:0] n;
    n = 4'h1;
    case (slc)
      SLC_EIGHT: n = 4'h8;
      SLC_FOUR: n = 4'h4;
      SLC_THREE: n = 4'h3;
      SLC_TWO: n = 4'h2;
      default: n = 4'h1;
    endcase
    return n;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [4:0] vlevel_r;
  logic [31:0] prdata_r;
  slc_bus_e st_r;
  logic clk_ok;
  logic [31:0] boost_cnt_r;
  logic circ_run_d_r;
  logic [6:0] slot_r;
  logic [2:0] com_cur_r;
  logic [2:0] com_next_r;
  logic [SEG_AW-1:0] scan_idx_r;
  logic [SEG_AW-1:0] cap_idx_r;
  logic cap_vld_r;
  logic [NUM_SEG-1:0] row_r;
  logic [7:0] com_r;
  logic [NUM_SEG-1:0] seg_r;
  logic [7:0] mem_qa;
  logic [7:0] mem_qb;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic acc;
  logic in_data;
  logic in_mod;
  logic seg_ok;
  logic hit_reg;
  logic need_wait;
  logic [SEG_AW-1:0] seg_idx;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] merged;
  logic wr_done;

  assign acc = psel && penable;
  assign in_data = (paddr[11:8] == OFF_SEGDATA[11:8]);
  assign in_mod = (paddr[11:8] == OFF_SEGMOD[11:8]);
  assign seg_idx = paddr[SEG_AW+1:2];
  // the index field spans the whole window, so only alignment and the segment count matter
  assign seg_ok = (paddr[1:0] == 2'h0) && (int'(seg_idx) < NUM_SEG);
  assign hit_reg = (paddr == OFF_CTRL) || (paddr == OFF_VLEVEL) ||
                   (paddr == OFF_STATUS) || (paddr == OFF_DISPOFF);
  // reads always take one wait cycle so prdata comes from flops
  assign need_wait = !pwrite || in_mod;
  assign pready = (st_r == ST_WAIT) || !need_wait;
  assign pslverr = acc && pready && !(hit_reg || ((in_data || in_mod) && seg_ok));
  assign wr_done = acc && pready && pwrite && !pslverr;
  // masked rewrite: mask bit 1 keeps the stored bit, 0 takes the new one
  assign merged = (mem_qa & pwdata[15:8]) | (pwdata[7:0] & ~pwdata[15:8]); // RL3
  assign mem_we = wr_done && (in_data || (in_mod && st_r == ST_WAIT));
  assign mem_wdata = in_mod ? merged : pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: if (acc && need_wait) begin
          st_r <= ST_WAIT;
        end
        ST_WAIT: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // control and level registers
  // ----------------------------------------
  logic disp_active;
  logic boost_ready;
  logic gen_internal;
  logic [31:0] status;

  assign gen_internal = (ctrl_r[CT_GEN+:2] == GEN_BOOST) || (ctrl_r[CT_GEN+:2] == GEN_CAP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST; // RL4
    end else if (wr_done && paddr == OFF_CTRL) begin
      ctrl_r <= pwdata & 32'h0000_7f7f;
    end else if (wr_done && paddr == OFF_DISPOFF && pwdata[DO_OFF]) begin
      ctrl_r[CT_DISP] <= 1'b0; // RL12
      if (pwdata[DO_STOP]) begin
        ctrl_r[CT_CIRC] <= 1'b0; // RL12
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlevel_r <= VLEVEL_RST;
    end else if (wr_done && paddr == OFF_VLEVEL) begin
      vlevel_r <= pwdata[4:0];
    end
  end

  assign status = {26'h0, gen_sel_eff, boost_ready, disp_active, clk_ok,
                   mode_ok(ctrl_r[CT_WAVE], ctrl_r[CT_SLC+:3], ctrl_r[CT_BIAS+:2],
                           ctrl_r[CT_GEN+:2])};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (acc && st_r == ST_IDLE) begin
      case (paddr)
        OFF_CTRL: prdata_r <= ctrl_r;
        OFF_VLEVEL: prdata_r <= {27'h0, vlevel_r};
        OFF_STATUS: prdata_r <= status;
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = ((in_data || in_mod) && seg_ok) ? {24'h0, mem_qa} : prdata_r;

  // ----------------------------------------
  // drive voltage generator
  // ----------------------------------------
  // the circuit only runs for a generator that has one
  assign circuit_run = ctrl_r[CT_CIRC] && gen_internal;
  assign gen_sel_eff = circuit_run ? ctrl_r[CT_GEN+:2] : GEN_RES; // RL13
  assign boost_init_ctrl = ctrl_r[CT_BINIT];
  assign ref_level = vlevel_r;
  assign lcd_clk_sel = ctrl_r[CT_CLK+:2];

  // boost wait timer; status tells software when the supply has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      circ_run_d_r <= 1'b0;
      boost_cnt_r <= 32'h0000_0000;
    end else begin
      circ_run_d_r <= circuit_run;
      if (!circuit_run) begin
        boost_cnt_r <= 32'h0000_0000;
      end else if (!circ_run_d_r) begin
        boost_cnt_r <= 32'(BOOST_WAIT_CYC);
      end else if (boost_cnt_r != 32'h0000_0000) begin
        boost_cnt_r <= boost_cnt_r - 32'h0000_0001;
      end
    end
  end
  assign boost_ready = circuit_run && circ_run_d_r && (boost_cnt_r == 32'h0000_0000);

  slc_sync u_clk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(lcd_clk_running),
    .q(clk_ok)
  );

  // a stopped clock source or an illegal mode keeps the glass dark
  assign disp_active = ctrl_r[CT_DISP] && clk_ok && status[0]; // RL11

  // ----------------------------------------
  // display store
  // ----------------------------------------
  slc_seg_mem u_mem (
    .pclk(pclk),
    .a_addr(seg_idx),
    .a_we(mem_we),
    .a_wdata(mem_wdata),
    .a_q(mem_qa),
    .b_addr(scan_idx_r),
    .b_q(mem_qb)
  );

  // ----------------------------------------
  // common scan
  // ----------------------------------------
  logic slot_end;
  logic [2:0] bit_idx;
  logic [3:0] ncom;

  assign ncom = num_com(ctrl_r[CT_SLC+:3]);
  assign slot_end = (slot_r == 7'(SLOT_CYC - 1));
  // 8 slices use the whole byte; otherwise the area picks the nibble
  assign bit_idx = (ctrl_r[CT_SLC+:3] == SLC_EIGHT) ? com_next_r :
                   {ctrl_r[CT_AREA], com_next_r[1:0]}; // RL1 RL2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_r <= 7'h00;
      scan_idx_r <= '0;
      cap_idx_r <= '0;
      cap_vld_r <= 1'b0;
      row_r <= '0;
    end else begin
      slot_r <= slot_end ? 7'h00 : slot_r + 7'h01;
      scan_idx_r <= slot_end ? '0 :
                    (int'(scan_idx_r) < NUM_SEG - 1) ? scan_idx_r + 1'b1 : scan_idx_r;
      cap_idx_r <= scan_idx_r;
      cap_vld_r <= (int'(slot_r) < NUM_SEG);
      if (cap_vld_r) begin
        row_r[cap_idx_r] <= mem_qb[bit_idx]; // RL2
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_cur_r <= 3'h0;
      com_next_r <= 3'h0;
      com_r <= 8'h00;
      seg_r <= '0;
    end else if (slot_end) begin
      com_cur_r <= com_next_r;
      com_next_r <= ({1'b0, com_next_r} + 4'h1 >= ncom) ? 3'h0 : com_next_r + 3'h1;
      com_r <= disp_active ? (8'h01 << com_next_r) : 8'h00; // RL11
      seg_r <= disp_active ? row_r : '0; // RL11
    end else if (!disp_active) begin
      com_r <= 8'h00;
      seg_r <= '0;
    end
  end

  assign com_out = com_r;
  assign seg_out = seg_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_off_stop;
    wr_done && paddr == OFF_DISPOFF && pwdata[DO_OFF] && pwdata[DO_STOP];
  endsequence
  sequence s_dark;
    !ctrl_r[CT_DISP] && !ctrl_r[CT_CIRC];
  endsequence

  AST_OFF_STOP: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    s_off_stop |=> s_dark ##1 (com_out == 8'h00))
    else $error("display off with stop left display or circuit running");
  AST_FALLBACK: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    !ctrl_r[CT_CIRC] |-> gen_sel_eff == GEN_RES)
    else $error("stopped circuit did not fall back to resistor division");
  AST_DARK: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    !disp_active |=> com_out == 8'h00 && seg_out == '0)
    else $error("glass driven while display inactive");
  AST_NIBBLE: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    ctrl_r[CT_SLC+:3] != SLC_EIGHT |-> bit_idx[2] == ctrl_r[CT_AREA])
    else $error("pattern area picked the wrong nibble");
  AST_COMBIT: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    slot_end && disp_active |=> com_out == (8'h01 << com_cur_r))
    else $error("active common does not match scanned bit");
  AST_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    mem_we && in_mod |-> (mem_wdata & pwdata[15:8]) == (mem_qa & pwdata[15:8]))
    else $error("masked rewrite changed a kept bit");
  AST_AREA_RST: assert property (@(posedge pclk) // RL4
    $rose(presetn) |-> ctrl_r[CT_AREA] == AREA_A)
    else $error("display area not A-pattern after reset");
  AST_BOOST_WAIT: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    $rose(circuit_run) |-> !boost_ready [*2])
    else $error("boost reported ready without wait");
endmodule

// ==== test_slc_top.sv ====
// self-checking bench of the segment lcd controller
`timescale 1ns/10ps
module test_slc_top;
  import slc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, lcd_clk_running;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ctrl;
  logic pready, pslverr, circuit_run, boost_init_ctrl;
  logic [1:0] gen_sel_eff, lcd_clk_sel;
  logic [4:0] ref_level;
  logic [7:0] com_out, b;
  logic [39:0] seg_out;
  logic [319:0] rows;
  int miscompares = 0;
  int checks = 0;
  // ----------------------------------------
  // design and glass
  // ----------------------------------------
  slc_top #(.BOOST_WAIT_US(1), .BOOST_WAIT_CYC(10)) u_slc_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lcd_clk_running(lcd_clk_running),
    .gen_sel_eff(gen_sel_eff), .circuit_run(circuit_run), .boost_init_ctrl(boost_init_ctrl),
    .ref_level(ref_level), .lcd_clk_sel(lcd_clk_sel), .com_out(com_out), .seg_out(seg_out));
  slc_glass_model u_slc_glass_model (.pclk(pclk), .presetn(presetn), .com_out(com_out),
    .seg_out(seg_out), .rows_r(rows));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // pready is sampled at the rising edge itself; only the watchdog ends a wait
  // one more edge before returning, so outputs updated by the access have settled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(e, experr);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk(e, experr);
  endtask
  // settle the row pipeline, then compare commons 0..3 of segment 5 with nibble n of b
  task automatic glass(input int n);
    repeat (900) @(posedge pclk);
    for (int i = 0; i < 4; i++) chk(rows[i*40+5], b[n*4+i]);
  endtask
  task automatic summarize();
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, lcd_clk_running} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    lcd_clk_running <= 1'b1;
    rd(OFF_CTRL, 32'h0, 1'b0);
    rd(OFF_VLEVEL, 32'h0c, 1'b0);
    // init in order, boost generator, four slices, 1/3 bias, area a
    ctrl = 32'h4;
    wr(OFF_CTRL, ctrl, 1'b0);
    ctrl = ctrl | 32'h130;
    wr(OFF_CTRL, ctrl, 1'b0);
    ctrl = ctrl | 32'h400;
    wr(OFF_CTRL, ctrl, 1'b0);
    ctrl = ctrl | 32'h2000;
    wr(OFF_CTRL, ctrl, 1'b0);
    wr(OFF_VLEVEL, 32'h0d, 1'b0);
    ctrl = ctrl | 32'h2;
    wr(OFF_CTRL, ctrl, 1'b0);
    chk({circuit_run, gen_sel_eff, boost_init_ctrl, ref_level, lcd_clk_sel},
      {1'b1, GEN_BOOST, 1'b1, 5'h0d, 2'h1});
    rd(OFF_STATUS, 32'h13, 1'b0);
    repeat (10) @(posedge pclk);
    b = 8'h96;
    wr(OFF_SEGDATA + 12'h014, {24'h0, b}, 1'b0);
    rd(OFF_STATUS, 32'h1b, 1'b0);
    ctrl = ctrl | 32'h1;
    wr(OFF_CTRL, ctrl, 1'b0);
    rd(OFF_CTRL, ctrl, 1'b0);
    glass(0);
    // single-bit rewrites, masks 0xfe up to 0xf7
    for (int i = 0; i < 4; i++) begin
      b[i] = ~b[i];
      wr(OFF_SEGMOD + 12'h014, {16'h0, ~(8'h01 << i), b & (8'h01 << i)}, 1'b0);
      rd(OFF_SEGDATA + 12'h014, {24'h0, b}, 1'b0);
    end
    glass(0);
    ctrl = ctrl | 32'h1000;
    wr(OFF_CTRL, ctrl, 1'b0);
    glass(1);
    // display off only, then off plus circuit stop
    wr(OFF_DISPOFF, 32'h1, 1'b0);
    repeat (300) @(posedge pclk);
    chk({com_out, circuit_run, gen_sel_eff}, {8'h0, 1'b1, GEN_BOOST});
    rd(OFF_CTRL, ctrl & 32'hfffe, 1'b0);
    wr(OFF_CTRL, ctrl, 1'b0);
    wr(OFF_DISPOFF, 32'h3, 1'b0);
    chk({circuit_run, gen_sel_eff}, {1'b0, GEN_RES});
    rd(OFF_CTRL, ctrl & 32'hfffc, 1'b0);
    wr(OFF_CTRL, ctrl & 32'hfffe, 1'b0);
    chk({circuit_run, gen_sel_eff}, {1'b1, GEN_BOOST});
    // capacitor split and resistor generators
    wr(OFF_CTRL, (ctrl & 32'hf3fe) | 32'h800, 1'b0);
    chk({circuit_run, gen_sel_eff}, {1'b1, GEN_CAP});
    wr(OFF_CTRL, ctrl & 32'hf3fe, 1'b0);
    chk({circuit_run, gen_sel_eff}, {1'b0, GEN_RES});
    // unmapped place and segment index past the end
    rd(12'h010, 32'h0, 1'b1);
    wr(OFF_SEGDATA + 12'h0a0, 32'h55, 1'b1);
    // mid-run reset brings back area a; an unsupported mode keeps the glass dark
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h111, 1'b0);
    rd(OFF_STATUS, 32'h2, 1'b0);
    summarize();
  end
endmodule
